/* File: src/sfc_pkg.sv */
// Shared constants for the serial flash command block and its host
package sfc_pkg;
  // ****************************************
  // Opcodes
  // ****************************************
  localparam logic [7:0] OP_CHIP_ERASE_A = 8'hc7;
  localparam logic [7:0] OP_CHIP_ERASE_B = 8'h60;
  localparam logic [7:0] OP_SLEEP = 8'hb9;
  localparam logic [7:0] OP_WAKE_ID = 8'hab;
  localparam logic [7:0] OP_MFR_DEV_ID = 8'h90;
  localparam logic [7:0] OP_JEDEC_ID = 8'h9f;
  localparam logic [7:0] OP_OTP_ENTER = 8'h3a;
  localparam logic [7:0] OP_WRITE_DISABLE = 8'h04;
  localparam logic [7:0] OP_WRITE_ENABLE = 8'h06;
  localparam logic [7:0] OP_STATUS_READ = 8'h05;
  localparam logic [7:0] OP_STATUS_WRITE = 8'h01;
  localparam logic [7:0] OP_SECTOR_ERASE = 8'h20;
  // ****************************************
  // Identity (values arbitrary)
  // ****************************************
  localparam logic [7:0] MFR_ID = 8'h5a;
  localparam logic [7:0] DEV_ID = 8'h12;
  localparam logic [7:0] MEM_TYPE_ID = 8'h31;
  localparam logic [7:0] CAPACITY_ID = 8'h13;
  // ****************************************
  // Sizes and fields
  // ****************************************
  localparam logic [23:0] ADDR_DEV_FIRST = 24'h000001;
  localparam logic [23:0] OTP_BASE = 24'h07f000;
  localparam logic [23:0] OTP_LAST = 24'h07f0ff;
  localparam logic [2:0] BITS_PER_BYTE_M1 = 3'h7;
  localparam logic [2:0] PROT_NONE = 3'h0;
  localparam int ST_WIP = 0;
  localparam int ST_WEL = 1;
  localparam int ST_GUARD = 7;
  // ****************************************
  // Timing, 40 MHz clock
  // ****************************************
  localparam int CLK_NS = 25;
  localparam int ERASE_US = 1000;
  localparam int SLEEP_ENTRY_NS = 3000;
  localparam int WAKE_NS = 3000;
  localparam int WAKE_ID_NS = 1800;
  localparam int ERASE_CYC = ERASE_US * 1000 / CLK_NS;
  localparam int SLEEP_CYC = SLEEP_ENTRY_NS / CLK_NS;
  localparam int WAKE_CYC = (WAKE_NS + CLK_NS - 1) / CLK_NS;
  localparam int WAKE_ID_CYC = (WAKE_ID_NS + CLK_NS - 1) / CLK_NS;
  localparam int HOST_DIV = 4;
  localparam int TMR_W = 24;
endpackage

/* File: src/sfc_link_if.sv */
// Four-wire serial link between host and flash device
`timescale 1ns/1ps
interface sfc_link_if;
  logic cs_n;
  logic sclk;
  logic mosi;
  logic miso_o;
  logic miso_oe;
  wire miso = miso_oe ? miso_o : 1'b1;
  modport dev (input cs_n, input sclk, input mosi, output miso_o, output miso_oe);
  modport host (output cs_n, output sclk, output mosi, input miso);
endinterface

/* File: src/sfc_sync2.sv */
// Two-flop synchroniser for one level
`timescale 1ns/1ps
module sfc_sync2 (
  // Clock and reset
  input wire logic clk,
  input wire logic rst_n,
  // Level
  input wire logic d,
  output logic q
);
  logic meta_q;
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      meta_q <= 1'b1;
      q <= 1'b1;
    end else begin
      meta_q <= d;
      q <= meta_q;
    end
  end
endmodule

/* File: src/sfc_dev.sv */
// Flash device end: erase, power-down, identifier and OTP commands
// Operation
// - C7h or 60h erases whole array
// - Chip erase needs write enable latch set
// - Chip erase only if deselected after bit 8
// - Self-timed erase holds busy, status still readable
// - Erase completion clears write enable latch
// - Chip erase refused when any protection set
// - B9h then deselect enters power-down
// - Powered down: only ABh recognised
// - Reset comes up in normal state
// - Wake needs deselect held wake time
// - ABh plus 3 dummies streams device id
// - Id wake needs deselect held shorter
// - ABh ignored while busy
// - 90h address picks first id byte
// - 90h alternates ids until deselect
// - 9Fh sends manufacturer, type, capacity
// - 3Ah enters OTP, security sector mapped
// - OTP: guard bit reports lock, lock blocks writes
// - OTP status write sets lock bit
// - Security sector needs lock clear, no protection
// - 04h leaves OTP mode
// - OTP: only sector erase clears security sector
// - Sector erase is 20h plus 24-bit address
`timescale 1ns/1ps
module sfc_dev
  import sfc_pkg::*;
(
  // Clock and reset
  input wire logic clk,
  input wire logic rst_n,
  // Link
  sfc_link_if.dev link,
  // Status
  output logic busy,
  output logic asleep,
  output logic otp_mode,
  output logic lock_bit,
  output logic [2:0] protect_level_bits,
  output logic erase_pulse,
  output logic otp_erase_pulse
);
  // ****************************************
  // Pin sampling and edges
  // ****************************************
  logic cs_s, sclk_s, mosi_s;
  sfc_sync2 u_cs (.clk(clk), .rst_n(rst_n), .d(link.cs_n), .q(cs_s));
  sfc_sync2 u_ck (.clk(clk), .rst_n(rst_n), .d(link.sclk), .q(sclk_s));
  sfc_sync2 u_di (.clk(clk), .rst_n(rst_n), .d(link.mosi), .q(mosi_s));
  logic cs_d_q, ck_d_q;
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      cs_d_q <= 1'b1;
      ck_d_q <= 1'b0;
    end else begin
      cs_d_q <= cs_s;
      ck_d_q <= sclk_s;
    end
  end
  wire sel = !cs_s;
  wire cs_rise = cs_s && !cs_d_q;
  wire ck_rise = sel && sclk_s && !ck_d_q;
  wire ck_fall = sel && !sclk_s && ck_d_q;
  // ****************************************
  // Frame shifter
  // ****************************************
  logic [31:0] sh_q;
  logic [15:0] bitcnt_q;
  logic [7:0] op_q;
  logic [7:0] tx_q;
  logic [2:0] txbit_q;
  logic [1:0] idx_q;
  logic oe_q, dout_q, started_q;
  logic wel_q, wip_q, sleep_q, otp_q, lock_q, guard_q;
  logic [2:0] prot_q;
  logic [7:0] stwr_q;
  logic dev_first_q;
  logic [TMR_W-1:0] tmr_q;
  typedef enum {SFC_IDLE, SFC_ERASE, SFC_STWR, SFC_SECERASE, SFC_GOSLEEP, SFC_WAKE} sfc_state_t;
  sfc_state_t st_q;
  wire [7:0] rx_byte = {sh_q[6:0], mosi_s};
  wire op_done = ck_rise && bitcnt_q == 16'd7;
  wire idle = st_q == SFC_IDLE || st_q == SFC_GOSLEEP;
  wire eight_only = bitcnt_q == 16'd8;
  wire erase_ok = wel_q && prot_q == PROT_NONE && !(otp_q && lock_q);
  wire [7:0] status_byte = {(otp_q ? lock_q : guard_q), 1'b0, prot_q, 1'b0, wel_q, wip_q};
  // Next outgoing byte, chosen by command and byte index
  logic [7:0] next_tx;
  always_comb begin
    next_tx = 8'hff;
    case (op_q)
      OP_WAKE_ID: next_tx = DEV_ID;
      OP_MFR_DEV_ID: next_tx = (idx_q[0] ^ dev_first_q) ? DEV_ID : MFR_ID;
      OP_JEDEC_ID: next_tx = idx_q == 2'd0 ? MFR_ID : (idx_q == 2'd1 ? MEM_TYPE_ID : CAPACITY_ID);
      OP_STATUS_READ: next_tx = status_byte;
      default: next_tx = 8'hff;
    endcase
  end
  // Reply starts after opcode, plus 3 bytes for ABh/90h
  // ABh still answers while powered down, so an id read can also wake the part
  wire talker = (op_q == OP_WAKE_ID && !wip_q) || (!sleep_q && (op_q == OP_MFR_DEV_ID ||
    (op_q == OP_JEDEC_ID && !wip_q) || op_q == OP_STATUS_READ));
  wire [15:0] reply_at = (op_q == OP_WAKE_ID || op_q == OP_MFR_DEV_ID) ? 16'd32 : 16'd8;
  always_ff @(posedge clk) begin
    if (!rst_n || !sel) begin
      sh_q <= 32'h0;
      bitcnt_q <= 16'h0;
      op_q <= 8'h0;
      tx_q <= 8'hff;
      txbit_q <= BITS_PER_BYTE_M1;
      idx_q <= 2'd0;
      oe_q <= 1'b0;
      dout_q <= 1'b1;
      started_q <= 1'b0;
      dev_first_q <= 1'b0;
    end else begin
      if (ck_rise) begin
        sh_q <= {sh_q[30:0], mosi_s};
        if (bitcnt_q != 16'hffff)
          bitcnt_q <= bitcnt_q + 16'd1;
        if (op_done)
          op_q <= rx_byte;
        // Address is latched; the shifter keeps moving during the reply
        if (bitcnt_q == 16'd31)
          dev_first_q <= {sh_q[22:0], mosi_s} == ADDR_DEV_FIRST;
      end
      if (ck_fall && talker && bitcnt_q >= reply_at) begin
        oe_q <= 1'b1;
        dout_q <= started_q ? tx_q[txbit_q] : next_tx[BITS_PER_BYTE_M1]; // MSB first
        if (!started_q) begin
          tx_q <= next_tx;
          txbit_q <= BITS_PER_BYTE_M1 - 3'd1;
          started_q <= 1'b1;
          idx_q <= idx_q + 2'd1;
        end else if (txbit_q == 3'd0) begin
          started_q <= 1'b0; // reload at next fall
          txbit_q <= BITS_PER_BYTE_M1;
        end else begin
          txbit_q <= txbit_q - 3'd1;
        end
      end
    end
  end
  // ****************************************
  // Command execution on deselect
  // ****************************************
  wire go_erase = cs_rise && eight_only && !wip_q && !sleep_q && st_q == SFC_IDLE &&
    (op_q == OP_CHIP_ERASE_A || op_q == OP_CHIP_ERASE_B) && erase_ok;
  wire go_sleep = cs_rise && eight_only && !wip_q && !sleep_q && idle && op_q == OP_SLEEP;
  wire go_wake = cs_rise && sleep_q && bitcnt_q >= 16'd8 && op_q == OP_WAKE_ID;
  wire plain = cs_rise && eight_only && !wip_q && !sleep_q && st_q == SFC_IDLE;
  wire go_stwr = cs_rise && bitcnt_q == 16'd16 && !wip_q && !sleep_q && op_q == OP_STATUS_WRITE && wel_q &&
    !(otp_q && lock_q);
  wire sec_in_otp = sh_q[23:0] >= OTP_BASE && sh_q[23:0] <= OTP_LAST;
  wire go_sec = cs_rise && bitcnt_q == 16'd32 && !wip_q && !sleep_q && op_q == OP_SECTOR_ERASE && wel_q &&
    otp_q && sec_in_otp && !lock_q && prot_q == PROT_NONE;
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      st_q <= SFC_IDLE;
      sleep_q <= 1'b0;
      wel_q <= 1'b0;
      wip_q <= 1'b0;
      otp_q <= 1'b0;
      lock_q <= 1'b0;
      guard_q <= 1'b0;
      prot_q <= PROT_NONE;
      stwr_q <= 8'h0;
      tmr_q <= '0;
      erase_pulse <= 1'b0;
      otp_erase_pulse <= 1'b0;
    end else begin
      erase_pulse <= 1'b0;
      otp_erase_pulse <= 1'b0;
      if (plain && op_q == OP_WRITE_ENABLE)
        wel_q <= 1'b1;
      if (plain && op_q == OP_WRITE_DISABLE) begin
        wel_q <= 1'b0;
        otp_q <= 1'b0;
      end
      if (plain && op_q == OP_OTP_ENTER)
        otp_q <= 1'b1;
      case (st_q)
        SFC_IDLE: begin
          if (go_erase) begin
            st_q <= SFC_ERASE;
            wip_q <= 1'b1;
            tmr_q <= TMR_W'(ERASE_CYC);
          end else if (go_sec) begin
            st_q <= SFC_SECERASE;
            wip_q <= 1'b1;
            tmr_q <= TMR_W'(ERASE_CYC);
          end else if (go_stwr) begin
            st_q <= SFC_STWR;
            wip_q <= 1'b1;
            stwr_q <= sh_q[7:0]; // Shifter clears on deselect, so keep the data byte
            tmr_q <= TMR_W'(SLEEP_CYC);
          end else if (go_sleep) begin
            st_q <= SFC_GOSLEEP;
            tmr_q <= TMR_W'(SLEEP_CYC);
          end else if (go_wake) begin
            st_q <= SFC_WAKE;
            tmr_q <= bitcnt_q > 16'd8 ? TMR_W'(WAKE_ID_CYC) : TMR_W'(WAKE_CYC);
          end
        end
        SFC_ERASE, SFC_SECERASE, SFC_STWR: begin
          tmr_q <= tmr_q - TMR_W'(1);
          if (tmr_q == TMR_W'(1)) begin
            st_q <= SFC_IDLE;
            wip_q <= 1'b0;
            wel_q <= 1'b0;
            if (st_q == SFC_ERASE)
              erase_pulse <= 1'b1; // Security sector untouched
            if (st_q == SFC_SECERASE)
              otp_erase_pulse <= 1'b1;
            if (st_q == SFC_STWR && otp_q)
              lock_q <= 1'b1;
            else if (st_q == SFC_STWR) begin
              guard_q <= stwr_q[ST_GUARD];
              prot_q <= stwr_q[4:2];
            end
          end
        end
        SFC_GOSLEEP: begin
          tmr_q <= tmr_q - TMR_W'(1);
          if (tmr_q == TMR_W'(1)) begin
            st_q <= SFC_IDLE;
            sleep_q <= 1'b1;
          end
        end
        SFC_WAKE: begin
          tmr_q <= tmr_q - TMR_W'(1);
          // Selecting early restarts the wait; the frame is not honoured
          if (sel)
            tmr_q <= bitcnt_q > 16'd8 ? TMR_W'(WAKE_ID_CYC) : TMR_W'(WAKE_CYC);
          else if (tmr_q == TMR_W'(1)) begin
            st_q <= SFC_IDLE;
            sleep_q <= 1'b0;
          end
        end
        default: st_q <= SFC_IDLE;
      endcase
    end
  end
  // ****************************************
  // Outputs
  // ****************************************
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      link.miso_o <= 1'b1;
      link.miso_oe <= 1'b0;
    end else begin
      link.miso_o <= dout_q;
      link.miso_oe <= oe_q && sel;
    end
  end
  assign busy = wip_q;
  assign asleep = sleep_q;
  assign otp_mode = otp_q;
  assign lock_bit = lock_q;
  assign protect_level_bits = prot_q;
endmodule

/* File: src/sfc_host.sv */
// Host end: runs one frame per software command
`timescale 1ns/1ps
module sfc_host
  import sfc_pkg::*;
(
  // Clock and reset
  input wire logic clk,
  input wire logic rst_n,
  // Software port
  input wire logic [1:0] addr,
  input wire logic [31:0] wdata,
  input wire logic wr,
  input wire logic rd,
  output logic [31:0] rdata,
  // Link
  sfc_link_if.host link
);
  // Registers: 0 tx word, 1 ctrl {nbytes[3:0]} write starts, 2 rx word, 3 status {busy}
  localparam logic [1:0] REG_TX = 2'h0;
  localparam logic [1:0] REG_CTRL = 2'h1;
  localparam logic [1:0] REG_RX = 2'h2;
  localparam logic [1:0] REG_STAT = 2'h3;
  logic [31:0] tx_q, rx_q;
  logic [3:0] left_q;
  logic [2:0] bit_q;
  logic [7:0] div_q;
  logic run_q, ck_q, miso_s, cs_q, tail_q;
  sfc_sync2 u_mi (.clk(clk), .rst_n(rst_n), .d(link.miso), .q(miso_s));
  wire start = wr && addr == REG_CTRL && !run_q;
  wire half = div_q == 8'(HOST_DIV - 1);
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      tx_q <= 32'h0;
      rx_q <= 32'h0;
      left_q <= 4'h0;
      bit_q <= BITS_PER_BYTE_M1;
      div_q <= 8'h0;
      run_q <= 1'b0;
      ck_q <= 1'b0;
      cs_q <= 1'b1;
      tail_q <= 1'b0;
      rdata <= 32'h0;
    end else begin
      if (rd)
        rdata <= addr == REG_RX ? rx_q : (addr == REG_STAT ? {31'h0, run_q} : tx_q);
      if (wr && addr == REG_TX && !run_q)
        tx_q <= wdata;
      if (start && wdata[3:0] != 4'h0) begin
        run_q <= 1'b1;
        cs_q <= 1'b0;
        left_q <= wdata[3:0];
        bit_q <= BITS_PER_BYTE_M1;
        div_q <= 8'h0;
      end else if (run_q) begin
        div_q <= half ? 8'h0 : div_q + 8'h1;
        if (half && tail_q) begin
          run_q <= 1'b0;
          tail_q <= 1'b0;
          cs_q <= 1'b1; // Deselect half a period after the last fall, clock low
        end else if (half) begin
          ck_q <= !ck_q;
          if (ck_q) begin
            // Sampled late: the reply takes longer than half a period to return
            rx_q <= {rx_q[30:0], miso_s};
            tx_q <= {tx_q[30:0], 1'b0};
            bit_q <= bit_q - 3'd1;
            if (bit_q == 3'd0) begin
              left_q <= left_q - 4'h1;
              if (left_q == 4'h1)
                tail_q <= 1'b1;
            end
          end
        end
      end
    end
  end
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      link.sclk <= 1'b0;
      link.mosi <= 1'b0;
      link.cs_n <= 1'b1;
    end else begin
      link.sclk <= ck_q;
      link.mosi <= tx_q[31];
      link.cs_n <= cs_q;
    end
  end
endmodule

/* File: tb/sfc_link_props.sv */
// Checker for the serial link between the host and device ends
`timescale 1ns/1ps
module sfc_link_props (
  // Clock and reset
  input wire logic clk,
  input wire logic rst_n,
  // Link wires
  input wire logic cs_n,
  input wire logic sclk,
  input wire logic mosi,
  input wire logic miso_o,
  input wire logic miso_oe
);
  // ****************************************
  // Link relations
  // ****************************************
  default clocking @(posedge clk);
  endclocking
  default disable iff (!rst_n);
  property p_idle_clk; cs_n |-> !sclk; endproperty
  a_idle_clk: assert property (p_idle_clk) else $error("clock runs while deselected");
  property p_cs_rise; $rose(cs_n) |-> $past(!sclk); endproperty
  a_cs_rise: assert property (p_cs_rise) else $error("deselect with clock high");
  property p_frame_min; $fell(cs_n) |-> !cs_n [*8]; endproperty
  a_frame_min: assert property (p_frame_min) else $error("frame too short");
  property p_high_pace; $rose(sclk) |-> sclk [*4]; endproperty
  a_high_pace: assert property (p_high_pace) else $error("clock high phase short");
  property p_low_pace; $fell(sclk) |-> !sclk [*4]; endproperty
  a_low_pace: assert property (p_low_pace) else $error("clock low phase short");
  property p_mosi_hold; (sclk && $past(sclk)) |-> $stable(mosi); endproperty
  a_mosi_hold: assert property (p_mosi_hold) else $error("data in moved while clock high");
  property p_oe_off; $rose(cs_n) |-> ##[0:4] !miso_oe; endproperty
  a_oe_off: assert property (p_oe_off) else $error("output still driven after deselect");
  property p_oe_idle; cs_n [*6] |-> !miso_oe; endproperty
  a_oe_idle: assert property (p_oe_idle) else $error("output driven while idle");
  property p_out_quiet; (!miso_oe && $past(!miso_oe)) |-> miso_o; endproperty
  a_out_quiet: assert property (p_out_quiet) else $error("output data moved while undriven");
endmodule

/* File: tb/spi_flash_erase_id_otp_cmds_bench.sv */
// Bench joining host and device ends over the serial link
`timescale 1ns/1ps
module spi_flash_erase_id_otp_cmds_bench;
  import sfc_pkg::*;
  logic clk, rst_n, wr, rd, busy, asleep, otp_mode, lock_bit, erase_pulse, otp_erase_pulse;
  logic [1:0] addr;
  logic [2:0] protect_level_bits;
  logic [31:0] wdata, rdata, rx;
  logic [23:0] n_erase = 24'h0;
  int n_mismatch = 0;
  int n_checks = 0;
  sfc_link_if link ();
  sfc_dev u_sfc_dev (.clk(clk), .rst_n(rst_n), .link(link), .busy(busy), .asleep(asleep),
    .otp_mode(otp_mode), .lock_bit(lock_bit), .protect_level_bits(protect_level_bits),
    .erase_pulse(erase_pulse), .otp_erase_pulse(otp_erase_pulse));
  sfc_host u_sfc_host (.clk(clk), .rst_n(rst_n), .addr(addr), .wdata(wdata), .wr(wr), .rd(rd),
    .rdata(rdata), .link(link));
  sfc_link_props u_sfc_link_props (.clk(clk), .rst_n(rst_n), .cs_n(link.cs_n), .sclk(link.sclk),
    .mosi(link.mosi), .miso_o(link.miso_o), .miso_oe(link.miso_oe));
  initial begin
    clk = 1'b0;
    forever #12.5 clk = ~clk;
  end
  always @(posedge clk) if (erase_pulse === 1'b1) n_erase <= n_erase + 24'h1;
  // ****************************************
  // Software port and link tasks
  // ****************************************
  task automatic chk(input logic [23:0] got, input logic [23:0] exp);
    n_checks++;
    if (got !== exp) begin
      n_mismatch++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic wreg(input logic [1:0] a, input logic [31:0] d);
    addr <= a;
    wdata <= d;
    wr <= 1'b1;
    @(posedge clk);
    wr <= 1'b0;
    @(posedge clk);
  endtask
  task automatic rreg(input logic [1:0] a, output logic [31:0] d);
    addr <= a;
    rd <= 1'b1;
    @(posedge clk);
    rd <= 1'b0;
    @(posedge clk);
    d = rdata;
  endtask
  // Bytes past the fourth go out as zeros, so dummies need no data
  task automatic frame(input logic [31:0] tx, input logic [3:0] nb);
    logic [31:0] st;
    int i;
    wreg(2'h0, tx);
    wreg(2'h1, {28'h0, nb});
    repeat (4) @(posedge clk);
    st = 32'h1;
    for (i = 0; i < 3000 && st[0] !== 1'b0; i++) rreg(2'h3, st);
    if (st[0] !== 1'b0) n_mismatch++;
    rreg(2'h2, rx);
    repeat (8) @(posedge clk);
  endtask
  task automatic cmd(input logic [7:0] op, input logic [3:0] nb);
    frame({op, 24'h0}, nb);
  endtask
  task automatic wait_dev(input int lim);
    int i;
    for (i = 0; i < lim && busy !== 1'b0; i++) @(posedge clk);
    @(posedge clk); // Let the completion pulse reach its counter
  endtask
  // ****************************************
  // Scenarios
  // ****************************************
  task automatic t_ids;
    chk({17'h0, asleep, otp_mode, lock_bit, busy, protect_level_bits}, 24'h0);
    cmd(OP_JEDEC_ID, 4'h4);
    chk(rx[23:0], {MFR_ID, MEM_TYPE_ID, CAPACITY_ID});
    cmd(OP_MFR_DEV_ID, 4'h7);
    chk(rx[23:0], {MFR_ID, DEV_ID, MFR_ID});
    frame({OP_MFR_DEV_ID, ADDR_DEV_FIRST}, 4'h7);
    chk(rx[23:0], {DEV_ID, MFR_ID, DEV_ID});
    cmd(OP_WAKE_ID, 4'h7);
    chk(rx[23:0], {3{DEV_ID}});
    cmd(8'h77, 4'h4);
    chk(rx[23:0], 24'hffffff);
    $display("ids done");
  endtask
  task automatic t_sleep;
    cmd(OP_SLEEP, 4'h1);
    repeat (SLEEP_CYC) @(posedge clk);
    chk({23'h0, asleep}, 24'h1);
    cmd(OP_STATUS_READ, 4'h2);
    chk(rx[23:0], 24'hffffff);
    cmd(OP_WAKE_ID, 4'h1);
    repeat (WAKE_CYC) @(posedge clk);
    chk({23'h0, asleep}, 24'h0);
    cmd(OP_SLEEP, 4'h1);
    repeat (SLEEP_CYC) @(posedge clk);
    cmd(OP_WAKE_ID, 4'h5);
    chk({16'h0, rx[7:0]}, {16'h0, DEV_ID});
    repeat (WAKE_ID_CYC) @(posedge clk);
    chk({23'h0, asleep}, 24'h0);
    $display("sleep done");
  endtask
  task automatic t_erase;
    cmd(OP_CHIP_ERASE_A, 4'h1);
    chk({23'h0, busy}, 24'h0);
    cmd(OP_WRITE_ENABLE, 4'h1);
    cmd(OP_CHIP_ERASE_B, 4'h2);
    chk({23'h0, busy}, 24'h0);
    cmd(OP_WRITE_ENABLE, 4'h1);
    cmd(OP_CHIP_ERASE_B, 4'h1);
    chk({23'h0, busy}, 24'h1);
    cmd(OP_WAKE_ID, 4'h7);
    chk(rx[23:0], 24'hffffff);
    cmd(OP_STATUS_READ, 4'h2);
    chk({22'h0, rx[ST_WEL], rx[ST_WIP]}, 24'h3);
    wait_dev(ERASE_CYC + 200);
    chk(n_erase, 24'h1);
    cmd(OP_STATUS_READ, 4'h2);
    chk({22'h0, rx[ST_WEL], rx[ST_WIP]}, 24'h0);
    $display("erase done");
  endtask
  task automatic t_protect;
    cmd(OP_WRITE_ENABLE, 4'h1);
    frame({OP_STATUS_WRITE, 8'h1c, 16'h0}, 4'h2);
    wait_dev(ERASE_CYC);
    chk({21'h0, protect_level_bits}, 24'h7);
    cmd(OP_WRITE_ENABLE, 4'h1);
    cmd(OP_CHIP_ERASE_A, 4'h1);
    chk({23'h0, busy}, 24'h0);
    cmd(OP_WRITE_ENABLE, 4'h1);
    cmd(OP_STATUS_WRITE, 4'h2);
    wait_dev(ERASE_CYC);
    chk({21'h0, protect_level_bits}, 24'h0);
    $display("protect done");
  endtask
  // Locking is one-way, so this runs last
  task automatic t_otp;
    cmd(OP_OTP_ENTER, 4'h1);
    chk({23'h0, otp_mode}, 24'h1);
    cmd(OP_WRITE_ENABLE, 4'h1);
    cmd(OP_STATUS_WRITE, 4'h2);
    wait_dev(ERASE_CYC);
    chk({23'h0, lock_bit}, 24'h1);
    cmd(OP_STATUS_READ, 4'h2);
    chk({23'h0, rx[ST_GUARD]}, 24'h1);
    cmd(OP_WRITE_ENABLE, 4'h1);
    frame({OP_SECTOR_ERASE, OTP_BASE}, 4'h4);
    chk({22'h0, busy, otp_erase_pulse}, 24'h0);
    cmd(OP_WRITE_DISABLE, 4'h1);
    chk({23'h0, otp_mode}, 24'h0);
    $display("otp done");
  endtask
  task automatic wrap_up;
    $display("checks %0d mismatches %0d", n_checks, n_mismatch);
    if (n_mismatch == 0 && n_checks > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask
  initial begin
    rst_n = 1'b0;
    wr = 1'b0;
    rd = 1'b0;
    addr = 2'h0;
    wdata = 32'h0;
    repeat (3) @(posedge clk);
    rst_n <= 1'b1;
    repeat (3) @(posedge clk);
    t_ids;
    t_sleep;
    t_erase;
    t_protect;
    t_otp;
    wrap_up;
  end
  // Erase dominates the run; this leaves twice the expected span
  initial begin
    repeat (100000) @(posedge clk);
    n_mismatch++;
    wrap_up;
  end
endmodule
